/* File: hw/ssl_pkg.sv */
// constants and types shared by the serdes sync and lock block
// assumes one system clock (pclk) and APB register access from software
package ssl_pkg;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 12;
  localparam int DATA_BITS = 10;
  localparam logic [11:0] SYNC_PATTERN = 12'hFC0;
  localparam logic [3:0] LAST_BIT_POS = 4'hB;
  localparam logic [3:0] HALF_FRAME = 4'h6;

  // ----------------------------------------------------------------
  // word clock counts
  // ----------------------------------------------------------------
  localparam logic [2:0] SYNC_QUAL_WORDS = 3'h6;
  localparam logic [10:0] SYNC_BURST_WORDS = 11'h402;
  localparam logic [10:0] SYNC_EXT_WORDS = 11'h404;
  localparam logic [10:0] SYNC_GAP_WORDS = 11'h004;
  localparam logic [10:0] INIT_WORDS = 11'h402;

  // ----------------------------------------------------------------
  // frame counts on the receive side
  // ----------------------------------------------------------------
  localparam logic [2:0] LOCK_FRAMES = 3'h4;
  localparam logic [2:0] UNLOCK_FRAMES = 3'h4;
  localparam logic [1:0] RMT_FRAMES = 2'h2;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RXWORD = 8'h08;
  localparam int CTRL_DRV_EN_BIT = 0;
  localparam int CTRL_PWR_N_BIT = 1;
  localparam int CTRL_RX_EN_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h7;
  localparam int ST_LOCK_N_BIT = 0;
  localparam int ST_RMT_BIT = 1;
  localparam int ST_BURST_BIT = 2;
  localparam int ST_TXRDY_BIT = 3;
  localparam int ST_MODE_LSB = 4;
  localparam int ST_POS_LSB = 8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SSL_MODE_INIT, SSL_MODE_SYNC, SSL_MODE_DATA, SSL_MODE_POWER_DOWN_N, SSL_MODE_HIZ
  } ssl_mode_e;
  typedef enum logic [1:0] {SSL_TX_IDLE, SSL_TX_BURST, SSL_TX_GAP} ssl_tx_e;
  typedef enum logic [1:0] {SSL_RX_INIT, SSL_RX_HUNT, SSL_RX_LOCKED} ssl_rx_e;

endpackage : ssl_pkg

/* File: hw/ssl_sync_request_b.sv */
// two flip-flop synchroniser for a vector of independent levels
// assumes each bit is a slow level or a clock much slower than clk
module ssl_sync_request_b #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : ssl_sync_request_b

/* File: hw/ssl_tx_sync.sv */
// serializer framing and sync burst generator, one frame per word tick
// assumes word_tick is a one-cycle pulse per word clock and req is already
// the or of both sync requests
module ssl_tx_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clr,
  // word side
  input wire logic word_tick,
  input wire logic req,
  input wire logic [ssl_pkg::DATA_BITS-1:0] din,
  // frame side
  output logic [ssl_pkg::FRAME_BITS-1:0] frame_q,
  output logic burst_q,
  output logic ready_q
);

  ssl_pkg::ssl_tx_e st_q;
  logic [2:0] qual_q;
  logic [10:0] cnt_q;
  logic [10:0] init_q;
  logic cont_q;
  logic [ssl_pkg::DATA_BITS-1:0] hold_q;
  logic [ssl_pkg::DATA_BITS-1:0] src;
  logic [ssl_pkg::FRAME_BITS-1:0] data_frame;
  logic start;
  logic ext_end;
  logic burst_end;
  logic gap_end;
  logic [ssl_pkg::FRAME_BITS-1:0] frame_d;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign start = (st_q == ssl_pkg::SSL_TX_IDLE) && req && ready_q
                 && (qual_q == ssl_pkg::SYNC_QUAL_WORDS - 3'h1);
  // a request held through the whole burst stretches it by two words
  assign ext_end = (cnt_q == ssl_pkg::SYNC_EXT_WORDS - 11'h001);
  assign burst_end = (st_q == ssl_pkg::SSL_TX_BURST)
                     && (ext_end || ((cnt_q == ssl_pkg::SYNC_BURST_WORDS - 11'h001)
                     && !(cont_q && req)));
  assign gap_end = (st_q == ssl_pkg::SSL_TX_GAP)
                   && (cnt_q == ssl_pkg::SYNC_GAP_WORDS - 11'h001);
  // inputs are frozen while a request is being qualified
  assign src = req ? hold_q : din;

  genvar gi;
  generate
    for (gi = 0; gi < ssl_pkg::DATA_BITS; gi++) begin : g_frame
      assign data_frame[ssl_pkg::FRAME_BITS-2-gi] = src[gi];
    end
  endgenerate
  assign data_frame[ssl_pkg::FRAME_BITS-1] = 1'b1;
  assign data_frame[0] = 1'b0;
  // the word that ends a burst is still a sync word; the gap's last word is data
  assign frame_d = (start || (st_q == ssl_pkg::SSL_TX_BURST))
                   ? ssl_pkg::SYNC_PATTERN : data_frame;

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ssl_pkg::SSL_TX_IDLE;
      qual_q <= 3'h0;
      cnt_q <= 11'h000;
      init_q <= 11'h000;
      cont_q <= 1'b0;
      hold_q <= '0;
      frame_q <= '0;
      burst_q <= 1'b0;
      ready_q <= 1'b0;
    end else if (ce) begin
      if (clr) begin
        st_q <= ssl_pkg::SSL_TX_IDLE;
        qual_q <= 3'h0;
        cnt_q <= 11'h000;
        init_q <= 11'h000;
        cont_q <= 1'b0;
        burst_q <= 1'b0;
        ready_q <= 1'b0;
      end else if (word_tick) begin
        if (!ready_q) begin
          init_q <= init_q + 11'h001;
          ready_q <= (init_q == ssl_pkg::INIT_WORDS - 11'h001);
        end
        if (!req) begin
          hold_q <= din;
        end
        frame_q <= frame_d;
        case (st_q)
          ssl_pkg::SSL_TX_IDLE: begin
            qual_q <= (req && qual_q != ssl_pkg::SYNC_QUAL_WORDS) ? qual_q + 3'h1 : 3'h0;
            if (start) begin
              st_q <= ssl_pkg::SSL_TX_BURST;
              cnt_q <= 11'h001;
              cont_q <= 1'b1;
              burst_q <= 1'b1;
            end
          end
          ssl_pkg::SSL_TX_BURST: begin
            cnt_q <= cnt_q + 11'h001;
            cont_q <= cont_q && req;
            if (burst_end) begin
              cnt_q <= 11'h000;
              burst_q <= 1'b0;
              qual_q <= 3'h0;
              // a one-off burst returns to live data
              st_q <= ext_end ? ssl_pkg::SSL_TX_GAP : ssl_pkg::SSL_TX_IDLE;
            end
          end
          ssl_pkg::SSL_TX_GAP: begin
            cnt_q <= cnt_q + 11'h001;
            if (gap_end) begin
              st_q <= ssl_pkg::SSL_TX_BURST;
              cnt_q <= 11'h000;
              cont_q <= 1'b0;
              burst_q <= 1'b1;
            end
          end
          default: begin
            st_q <= ssl_pkg::SSL_TX_IDLE;
          end
        endcase
      end
    end
  end

endmodule : ssl_tx_sync

/* File: hw/ssl_top.sv */
// serdes link start-up: sync burst generation, boundary lock and APB regs
// assumes pclk is the deserializer reference clock and that link pins,
// word clock and bit clock are asynchronous to it and much slower
//
// The register addresses and the APB slave port were chosen for this implementation.

// Function
// - six-cycle sync request sends 1026 sync words
// - a started burst runs to completion unless power-down clears it
// - short request gives one burst, then data
// - long request: 1028 sync, 4 data, 1026 sync
// - sync word is six ones, six zeros
// - serial output disabled until transmit init completes
// - receiver starts hunting on first rising input edge
// - lock flag high while acquiring, low locked
// - recovered data output while lock flag low
// - lock also acquired on data with one rising edge per frame
// - several rising edges per frame means risk
// - risky pattern holds lock off until changed
// - lock after four frames, same unique boundary
// - locked state ignores multitransition data patterns
// - four missed boundaries drop lock, hunt again
// - unlock: flag high, data and clock disabled
// - five link modes reported
// - frame is start one, ten data, stop zero
// - one twelve-bit frame per word clock
// - data ignored while request is qualifying
module ssl_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serializer pins
  input wire logic transmit_word_clock,
  input wire logic sync_request_a,
  input wire logic sync_request_b,
  input wire logic [ssl_pkg::DATA_BITS-1:0] parallel_input_word,
  output logic [ssl_pkg::FRAME_BITS-1:0] serial_frame,
  output logic serial_frame_oe,
  // deserializer pins
  input wire logic serial_bit_clock,
  input wire logic serial_in,
  output logic [ssl_pkg::DATA_BITS-1:0] parallel_output_word,
  output logic parallel_output_oe,
  output logic recovered_clock,
  output logic recovered_clock_oe,
  output logic lock_n
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = ssl_pkg::DATA_BITS + 5;
  logic [SYNC_W-1:0] pins_s;
  logic wclk_s;
  logic bclk_s;
  logic bit_s;
  logic req_s;
  logic [ssl_pkg::DATA_BITS-1:0] din_s;

  ssl_sync_request_b #(.W(SYNC_W)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .d({parallel_input_word, serial_in, serial_bit_clock, sync_request_b,
        sync_request_a, transmit_word_clock}),
    .q(pins_s)
  );

  assign wclk_s = pins_s[0];
  assign req_s = pins_s[1] | pins_s[2];
  assign bclk_s = pins_s[3];
  assign bit_s = pins_s[4];
  assign din_s = pins_s[SYNC_W-1:5];

  // ----------------------------------------------------------------
  // control register and edge finders
  // ----------------------------------------------------------------
  logic [2:0] ctrl_q;
  logic wclk_d_q;
  logic bclk_d_q;
  logic word_tick;
  logic bit_tick;
  logic drv_en;
  logic pwr_n;
  logic rx_en;

  assign drv_en = ctrl_q[ssl_pkg::CTRL_DRV_EN_BIT];
  assign pwr_n = ctrl_q[ssl_pkg::CTRL_PWR_N_BIT];
  assign rx_en = ctrl_q[ssl_pkg::CTRL_RX_EN_BIT];
  assign word_tick = wclk_s && !wclk_d_q;
  assign bit_tick = bclk_s && !bclk_d_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wclk_d_q <= 1'b0;
      bclk_d_q <= 1'b0;
    end else if (ce) begin
      wclk_d_q <= wclk_s;
      bclk_d_q <= bclk_s;
    end
  end

  // ----------------------------------------------------------------
  // serializer
  // ----------------------------------------------------------------
  logic [ssl_pkg::FRAME_BITS-1:0] tx_frame;
  logic tx_burst;
  logic tx_ready;

  // the 12x bit shifter sits in the analog serializer; this end hands it
  // one complete frame per word clock
  ssl_tx_sync u_tx (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .clr(!pwr_n),
    .word_tick(word_tick),
    .req(req_s),
    .din(din_s),
    .frame_q(tx_frame),
    .burst_q(tx_burst),
    .ready_q(tx_ready)
  );

  // ----------------------------------------------------------------
  // receiver boundary search
  // ----------------------------------------------------------------
  ssl_pkg::ssl_rx_e rx_q;
  logic [ssl_pkg::FRAME_BITS-1:0] shift_q;
  logic [3:0] bitpos_q;
  logic [1:0] trans_q;
  logic [3:0] tpos_q;
  logic [3:0] last_pos_q;
  logic [3:0] lock_pos_q;
  logic [2:0] match_q;
  logic [2:0] miss_q;
  logic [1:0] rmt_run_q;
  logic hit_q;
  logic [ssl_pkg::DATA_BITS-1:0] word_q;
  logic rclk_q;
  logic rise;
  logic frame_end;
  logic [1:0] trans_now;
  logic [3:0] pos_now;
  logic [2:0] match_next;
  logic [1:0] rmt_next;
  logic rmt_flag;
  logic lock_ok;
  logic at_lock;
  logic hit_now;
  logic capture;
  logic [3:0] half_pos;
  logic [ssl_pkg::DATA_BITS-1:0] word_d;
  logic locked;

  // a frame position counter free-runs; the true boundary is the only
  // low-to-high step that recurs at one position every frame
  assign rise = bit_tick && bit_s && !shift_q[0];
  assign frame_end = bit_tick && (bitpos_q == ssl_pkg::LAST_BIT_POS);
  assign trans_now = (rise && trans_q != 2'h2) ? trans_q + 2'h1 : trans_q;
  assign pos_now = rise ? bitpos_q : tpos_q;
  assign match_next = (trans_now != 2'h1) ? 3'h0
                    : (pos_now != last_pos_q) ? 3'h1
                    : (match_q == ssl_pkg::LOCK_FRAMES) ? match_q : match_q + 3'h1;
  assign rmt_next = (trans_now < 2'h2) ? 2'h0
                  : (rmt_run_q == ssl_pkg::RMT_FRAMES) ? rmt_run_q : rmt_run_q + 2'h1;
  assign rmt_flag = (rmt_run_q == ssl_pkg::RMT_FRAMES);
  assign lock_ok = (match_next == ssl_pkg::LOCK_FRAMES) && !rmt_flag;
  assign at_lock = rise && (bitpos_q == lock_pos_q);
  assign hit_now = hit_q || at_lock;
  assign locked = (rx_q == ssl_pkg::SSL_RX_LOCKED);
  assign capture = locked && at_lock;
  assign half_pos = (lock_pos_q >= ssl_pkg::HALF_FRAME) ? lock_pos_q - ssl_pkg::HALF_FRAME
                                                       : lock_pos_q + ssl_pkg::HALF_FRAME;

  genvar gi;
  generate
    for (gi = 0; gi < ssl_pkg::DATA_BITS; gi++) begin : g_word
      assign word_d[gi] = shift_q[ssl_pkg::FRAME_BITS-2-gi];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q <= ssl_pkg::SSL_RX_INIT;
      shift_q <= '0;
      bitpos_q <= 4'h0;
      trans_q <= 2'h0;
      tpos_q <= 4'h0;
      last_pos_q <= 4'h0;
      lock_pos_q <= 4'h0;
      match_q <= 3'h0;
      miss_q <= 3'h0;
      rmt_run_q <= 2'h0;
      hit_q <= 1'b0;
      word_q <= '0;
      rclk_q <= 1'b0;
    end else if (ce) begin
      if (!pwr_n) begin
        rx_q <= ssl_pkg::SSL_RX_INIT;
        match_q <= 3'h0;
        miss_q <= 3'h0;
        rmt_run_q <= 2'h0;
        rclk_q <= 1'b0;
      end else if (bit_tick) begin
        shift_q <= {shift_q[ssl_pkg::FRAME_BITS-2:0], bit_s};
        bitpos_q <= frame_end ? 4'h0 : bitpos_q + 4'h1;
        trans_q <= frame_end ? 2'h0 : trans_now;
        tpos_q <= pos_now;
        hit_q <= frame_end ? 1'b0 : hit_now;
        if (capture) begin
          word_q <= word_d;
          rclk_q <= 1'b1;
        end else if (bitpos_q == half_pos) begin
          rclk_q <= 1'b0;
        end
        case (rx_q)
          ssl_pkg::SSL_RX_INIT: begin
            if (rise) begin
              rx_q <= ssl_pkg::SSL_RX_HUNT;
            end
          end
          ssl_pkg::SSL_RX_HUNT: begin
            if (frame_end) begin
              match_q <= match_next;
              last_pos_q <= pos_now;
              rmt_run_q <= rmt_next;
              if (lock_ok) begin
                rx_q <= ssl_pkg::SSL_RX_LOCKED;
                lock_pos_q <= pos_now;
                miss_q <= 3'h0;
              end
            end
          end
          ssl_pkg::SSL_RX_LOCKED: begin
            if (frame_end) begin
              miss_q <= hit_now ? 3'h0 : miss_q + 3'h1;
              if (!hit_now && miss_q == ssl_pkg::UNLOCK_FRAMES - 3'h1) begin
                rx_q <= ssl_pkg::SSL_RX_HUNT;
                match_q <= 3'h0;
                rmt_run_q <= 2'h0;
                rclk_q <= 1'b0;
              end
            end
          end
          default: begin
            rx_q <= ssl_pkg::SSL_RX_INIT;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // link mode and registered pin outputs
  // ----------------------------------------------------------------
  ssl_pkg::ssl_mode_e mode_q;
  ssl_pkg::ssl_mode_e mode_d;

  assign mode_d = !pwr_n ? ssl_pkg::SSL_MODE_POWER_DOWN_N
                : !drv_en ? ssl_pkg::SSL_MODE_HIZ
                : !tx_ready ? ssl_pkg::SSL_MODE_INIT
                : (tx_burst || !locked) ? ssl_pkg::SSL_MODE_SYNC
                : ssl_pkg::SSL_MODE_DATA;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= ssl_pkg::SSL_MODE_INIT;
      serial_frame <= '0;
      serial_frame_oe <= 1'b0;
      parallel_output_word <= '0;
      parallel_output_oe <= 1'b0;
      recovered_clock <= 1'b0;
      recovered_clock_oe <= 1'b0;
      lock_n <= 1'b1;
    end else if (ce) begin
      mode_q <= mode_d;
      serial_frame <= tx_frame;
      serial_frame_oe <= tx_ready && drv_en && pwr_n;
      parallel_output_word <= word_q;
      // data and clock float whenever lock is absent or the receiver is off
      parallel_output_oe <= locked && rx_en && pwr_n;
      recovered_clock <= rclk_q;
      recovered_clock_oe <= locked && rx_en && pwr_n;
      lock_n <= !locked;
    end
  end

  // ----------------------------------------------------------------
  // apb slave, one wait-free access phase
  // ----------------------------------------------------------------
  logic setup;
  logic access;
  logic addr_hit;
  logic [31:0] rd_mux;

  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign addr_hit = (paddr == ssl_pkg::ADDR_CTRL) || (paddr == ssl_pkg::ADDR_STATUS)
                    || (paddr == ssl_pkg::ADDR_RXWORD);
  assign rd_mux = (paddr == ssl_pkg::ADDR_CTRL) ? {29'h0000000, ctrl_q}
                : (paddr == ssl_pkg::ADDR_STATUS)
                  ? {20'h00000, lock_pos_q, 1'b0, mode_q, tx_ready, tx_burst, rmt_flag, lock_n}
                : (paddr == ssl_pkg::ADDR_RXWORD) ? {22'h000000, word_q}
                : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ssl_pkg::CTRL_RESET;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= setup;
      pslverr <= setup && !addr_hit;
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
      end
      if (access && pwrite && paddr == ssl_pkg::ADDR_CTRL) begin
        ctrl_q <= pwdata[2:0];
      end
    end
  end

endmodule : ssl_top

/* File: verification/ssl_top_properties.sv */
// concurrent checks on the ports of the serdes sync and lock top
// assumes pclk is the only clock and presetn its async active-low reset
module ssl_top_properties (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // serializer
  input wire logic transmit_word_clock,
  input wire logic [ssl_pkg::FRAME_BITS-1:0] serial_frame,
  input wire logic serial_frame_oe,
  // deserializer
  input wire logic parallel_output_oe,
  input wire logic recovered_clock_oe,
  input wire logic lock_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wc_q;
  logic lk_q;
  logic [10:0] tick_q;
  logic [8:0] run_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // raw word clock edges are seen before the design's synchroniser, so the bound is safe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wc_q <= 1'h0;
      lk_q <= 1'h1;
      tick_q <= 11'h000;
      run_q <= 9'h000;
    end else begin
      wc_q <= transmit_word_clock;
      lk_q <= lock_n;
      if (transmit_word_clock && !wc_q && tick_q != 11'h7FF) tick_q <= tick_q + 11'h001;
      run_q <= (lock_n != lk_q) ? 9'h000 : ((run_q == 9'h1FF) ? run_q : run_q + 9'h001);
    end
  end
  a_frame_bits: assert property (serial_frame_oe |-> serial_frame[11] && !serial_frame[0])
    else $error("frame without start or stop bit");
  a_frame_hold: assert property ($changed(serial_frame) |=> $stable(serial_frame) [*4])
    else $error("frame changed faster than the word clock");
  a_init_hold: assert property ($rose(serial_frame_oe) |-> tick_q >= ssl_pkg::INIT_WORDS)
    else $error("driver enabled before init count");
  a_lock_late: assert property ($fell(lock_n) |-> run_q >= 9'h12C)
    else $error("lock declared in fewer than four frames");
  a_unlock_late: assert property ($rose(lock_n) |-> run_q >= 9'h0FA)
    else $error("lock dropped in fewer than four frames");
  a_lock_oe: assert property (lock_n [*3] |-> !parallel_output_oe && !recovered_clock_oe)
    else $error("outputs driven while unlocked");
  a_oe_pair: assert property (parallel_output_oe == recovered_clock_oe)
    else $error("data and clock enables differ");
  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single access-cycle pulse");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule : ssl_top_properties

/* File: verification/ssl_peer_tx.sv */
// peer serializer model driving the receive link pins
// assumes a 400 ns bit period; bit clock stands still while idle
module ssl_peer_tx (
  // control from the bench
  input wire logic run,
  input wire logic no_edge,
  input wire logic [ssl_pkg::DATA_BITS-1:0] word,
  // link pins
  output logic bclk,
  output logic sdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] fr;
  initial begin
    bclk = 1'h0;
    sdata = 1'h0;
    forever begin
      if (!run) begin
        // released line toggles so no stale level reads as data
        sdata = ~sdata;
        #400;
      end else begin
        fr = 12'h800;
        for (int i = 0; i < 10; i++) fr[10-i] = word[i];
        if (no_edge) fr = 12'hFFF;
        for (int b = 11; b >= 0; b--) begin
          sdata = fr[b];
          #200 bclk = 1'h1;
          #200 bclk = 1'h0;
        end
      end
    end
  end
endmodule : ssl_peer_tx

/* File: verification/tb_serdes_sync_lock_control.sv */
// self-checking bench for the serdes sync and lock block
// assumes the peer model drives the receive pins and the bench the rest
module tb_serdes_sync_lock_control;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic w; logic [7:0] a; logic [31:0] wd, m, e; logic er;} ssl_row_s;
  ssl_row_s rows[7] = '{'{1'h0, 8'h00, 32'h0, 32'hFFFFFFFF, 32'h7, 1'h0},
    '{1'h1, 8'h00, 32'hFFFFFFFF, 32'h0, 32'h0, 1'h0}, '{1'h0, 8'h00, 32'h0, 32'hFFFFFFFF, 32'h7, 1'h0},
    '{1'h1, 8'h0C, 32'h1, 32'h0, 32'h0, 1'h1}, '{1'h0, 8'h0C, 32'h0, 32'hFFFFFFFF, 32'h0, 1'h1},
    '{1'h1, 8'h04, 32'hFFFF, 32'h0, 32'h0, 1'h0}, '{1'h0, 8'h04, 32'h0, 32'h1, 32'h1, 1'h0}};
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, serial_frame_oe, serial_bit_clock, serial_in, parallel_output_oe;
  logic recovered_clock, recovered_clock_oe, lock_n, cur_sync = 1'h0;
  logic transmit_word_clock = 1'h0, sync_request_a = 1'h0, sync_request_b = 1'h0;
  logic [9:0] parallel_input_word = 10'h000, parallel_output_word, pr_word = 10'h000;
  logic [11:0] serial_frame;
  logic pr_run = 1'h0, pr_noedge = 1'h0;
  int err_total = 0, total_checks = 0, cur = 0, runs[$];
  always #25 pclk = ~pclk;
  initial begin
    #137;
    forever #200 transmit_word_clock = ~transmit_word_clock;
  end
  ssl_top ssl_top_inst (.pclk, .presetn, .ce(1'h1), .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .transmit_word_clock, .sync_request_a, .sync_request_b,
    .parallel_input_word, .serial_frame, .serial_frame_oe, .serial_bit_clock, .serial_in,
    .parallel_output_word, .parallel_output_oe, .recovered_clock, .recovered_clock_oe, .lock_n);
  ssl_peer_tx ssl_peer_tx_inst (.run(pr_run), .no_edge(pr_noedge), .word(pr_word),
    .bclk(serial_bit_clock), .sdata(serial_in));
  // ---------------------------------------------------------------
  // run-length monitor: sync and data frames, one per word clock
  // ---------------------------------------------------------------
  always @(posedge transmit_word_clock) begin
    if ((serial_frame === 12'hFC0) != cur_sync) begin
      runs.push_back(cur_sync ? cur : -cur);
      cur = 0;
    end
    cur_sync = (serial_frame === 12'hFC0);
    cur++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    // only the watchdog ends a wait for ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic ticks(input int n);
    repeat (n) @(posedge transmit_word_clock);
    @(posedge pclk);
  endtask : ticks
  function automatic logic [11:0] data_frame(input logic [9:0] d);
    logic [11:0] f;
    f = 12'h800;
    for (int i = 0; i < 10; i++) f[10-i] = d[i];
    return f;
  endfunction : data_frame
  initial begin
    #4000000;
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    logic [31:0] rd;
    logic er;
    int n;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk(32'(lock_n), 32'h1, "lock flag while acquiring");
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].wd, rd, er);
      chk(rd & rows[i].m, rows[i].e, "apb read data");
      chk(32'(er), 32'(rows[i].er), "apb error flag");
    end
    parallel_input_word <= 10'h007;
    n = 0;
    while (serial_frame_oe !== 1'h1 && n < 12000) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(serial_frame_oe), 32'h1, "driver enabled after init");
    ticks(4);
    runs.delete();
    sync_request_a <= 1'h1;
    ticks(20);
    // request drops while the burst is still running
    sync_request_a <= 1'h0;
    ticks(1100);
    chk(runs.size(), 32'h2, "short request burst count");
    chk(runs[1], 32'd1026, "short burst length");
    chk(32'(serial_frame), 32'(data_frame(10'h007)), "live frame after burst");
    runs.delete();
    sync_request_b <= 1'h1;
    ticks(1100);
    sync_request_b <= 1'h0;
    ticks(1100);
    chk(runs.size(), 32'h4, "long request run count");
    chk(runs[1], 32'd1028, "long first burst");
    chk(-runs[2], 32'h4, "data frames between bursts");
    chk(runs[3], 32'd1026, "long second burst");
    pr_word <= 10'h2AA;
    pr_run <= 1'h1;
    repeat (2000) @(posedge pclk);
    chk(32'(lock_n), 32'h1, "lock held off on multi-rise data");
    pr_word <= 10'h007;
    n = 0;
    while (lock_n !== 1'h0 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(lock_n), 32'h0, "lock after clean frames");
    repeat (300) @(posedge pclk);
    chk(32'(parallel_output_word), 32'h007, "recovered word");
    chk(32'(parallel_output_oe), 32'h1, "outputs driven when locked");
    n = 0;
    while (recovered_clock !== 1'h1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(recovered_clock), 32'h1, "recovered clock pulse");
    pr_word <= 10'h2AA;
    repeat (1500) @(posedge pclk);
    chk(32'(lock_n), 32'h0, "lock kept on multi-rise data");
    pr_noedge <= 1'h1;
    repeat (800) @(posedge pclk);
    chk(32'({lock_n, parallel_output_oe, recovered_clock_oe}), 32'h4, "unlock");
    // lock flag copied once into a request: loss of lock must start a burst
    sync_request_a <= lock_n;
    ticks(8);
    chk(32'(serial_frame), 32'hFC0, "burst after lock loss");
    presetn <= 1'h0;
    @(posedge pclk);
    #1;
    chk(32'({lock_n, serial_frame_oe, pready}), 32'h4, "outputs in reset");
    tally_and_finish();
  end
endmodule : tb_serdes_sync_lock_control

bind ssl_top ssl_top_properties ssl_top_properties_inst (.pclk, .presetn, .psel, .penable,
  .pready, .pslverr, .transmit_word_clock, .serial_frame, .serial_frame_oe,
  .parallel_output_oe, .recovered_clock_oe, .lock_n);
